// ---- legacy_pin_function_mux.sv ----
// Multi-purpose pin function select registers and pin multiplexer
`timescale 1ns/1ns

module legacy_pin_function_mux (
  input wire logic clk,
  input wire logic arst_n,
  // Memory-mapped byte register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [pin_mux_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Configuration space dword port
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [pin_mux_pkg::CFG_ADDR_W-1:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output pin_mux_pkg::misc_cfg_s misc_cfg,
  // Power management context
  input wire logic segment_reset,
  input wire logic pme_enable,
  input wire logic in_d3,
  input wire logic pme_assert,
  // Legacy functions and general purpose I/O
  input wire pin_mux_pkg::legacy_s legacy,
  input wire logic [3:0] gpio_out,
  input wire logic [3:0] gpio_oe,
  output logic [3:0] gpio_in,
  output logic serial_irq_input_n,
  output logic hardware_suspend_input_n,
  // Serial power-control data engine
  input wire logic power_switch_serial_data_out,
  input wire logic power_switch_serial_data_oe,
  output logic power_switch_serial_data_in,
  // Pins
  input wire logic system_power_good,
  input wire logic [pin_mux_pkg::PIN131:0] pin_in,
  output pin_mux_pkg::pin_drive_s pin_203,
  output pin_mux_pkg::pin_drive_s pin_206,
  output pin_mux_pkg::pin_drive_s pin_128,
  output pin_mux_pkg::pin_drive_s pin_133,
  output pin_mux_pkg::pin_drive_s pin_204,
  output pin_mux_pkg::pin_drive_s pin_131
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic pin_mux_pkg::pin_func_e decode_sel(
    input logic [1:0] field,
    input logic gpio_ok,
    input logic pme_ok
  );
    pin_mux_pkg::pin_func_e func;
    func = pin_mux_pkg::FUNC_LEGACY;
    if (field == pin_mux_pkg::SEL_GPIO && gpio_ok) begin
      func = pin_mux_pkg::FUNC_GPIO;
    end else if (field == pin_mux_pkg::SEL_PME && pme_ok) begin
      func = pin_mux_pkg::FUNC_PME;
    end
    return func;
  endfunction
  // Active-low open-drain drive: pull low while asserted, float otherwise
  function automatic pin_mux_pkg::pin_drive_s open_drain(input logic assert_low);
    pin_mux_pkg::pin_drive_s d;
    d.out = 1'b0;
    d.oe = assert_low;
    return d;
  endfunction
  function automatic pin_mux_pkg::pin_drive_s gpio_drive(input logic o, input logic oe);
    pin_mux_pkg::pin_drive_s d;
    d.out = o;
    d.oe = oe;
    return d;
  endfunction

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [pin_mux_pkg::SYNC_W-1:0] sync_level;
  level_sync #(
    .WIDTH(pin_mux_pkg::SYNC_W)
  ) u_pin_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in({system_power_good, pin_in}),
    .sync_out(sync_level)
  );
  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [7:0] pin_sel0;
  logic [7:0] pin_sel1;
  logic [7:0] next_pin_sel0;
  logic [7:0] next_pin_sel1;
  logic [7:0] next_reg_rdata;
  logic [31:0] next_cfg_rdata;
  pin_mux_pkg::misc_cfg_s next_misc_cfg;
  logic sel_wr_ok;
  logic keep_context;
  always_comb begin
    next_pin_sel0 = pin_sel0;
    next_pin_sel1 = pin_sel1;
    next_misc_cfg = misc_cfg;
    next_reg_rdata = reg_rdata;
    next_cfg_rdata = cfg_rdata;
    sel_wr_ok = reg_wr && !misc_cfg.lock;
    // context kept across D3 soft reset
    keep_context = pme_enable && in_d3;
    if (sel_wr_ok && reg_addr == pin_mux_pkg::PIN_SEL0_OFFSET) begin
      next_pin_sel0 = reg_wdata;
    end
    // full byte stored, reserved bits too
    if (sel_wr_ok && reg_addr == pin_mux_pkg::PIN_SEL1_OFFSET) begin
      next_pin_sel1 = reg_wdata;
    end
    if (cfg_wr && cfg_addr == pin_mux_pkg::CFG_MISC_OFFSET) begin
      if (cfg_be[0]) begin
        next_misc_cfg.serial_intr_en = cfg_wdata[pin_mux_pkg::CFG_SERIAL_INTR_BIT];
      end
      if (cfg_be[1]) begin
        next_misc_cfg.lock = cfg_wdata[pin_mux_pkg::CFG_LOCK_BIT];
        next_misc_cfg.prefetch_off = cfg_wdata[pin_mux_pkg::CFG_PREFETCH_OFF_BIT];
        next_misc_cfg.auto_reset_off = cfg_wdata[pin_mux_pkg::CFG_AUTO_RESET_OFF_BIT];
      end
    end
    // Segment reset wins over a same-cycle write, except a select write while context is kept
    if (segment_reset) begin
      next_misc_cfg = '0;
      if (!keep_context) begin
        next_pin_sel0 = pin_mux_pkg::PIN_SEL0_RESET;
        next_pin_sel1 = pin_mux_pkg::PIN_SEL1_RESET;
      end
    end
    if (reg_rd) begin
      unique case (reg_addr)
        pin_mux_pkg::PIN_SEL0_OFFSET: next_reg_rdata = pin_sel0;
        pin_mux_pkg::PIN_SEL1_OFFSET: next_reg_rdata = pin_sel1;
        default: next_reg_rdata = 8'h00;
      endcase
    end
    if (cfg_rd) begin
      next_cfg_rdata = 32'h0000_0000;
      if (cfg_addr == pin_mux_pkg::CFG_MISC_OFFSET) begin
        next_cfg_rdata[pin_mux_pkg::CFG_SERIAL_INTR_BIT] = misc_cfg.serial_intr_en;
        next_cfg_rdata[pin_mux_pkg::CFG_LOCK_BIT] = misc_cfg.lock;
        next_cfg_rdata[pin_mux_pkg::CFG_PREFETCH_OFF_BIT] = misc_cfg.prefetch_off;
        next_cfg_rdata[pin_mux_pkg::CFG_AUTO_RESET_OFF_BIT] = misc_cfg.auto_reset_off;
      end
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_sel0 <= pin_mux_pkg::PIN_SEL0_RESET;
      pin_sel1 <= pin_mux_pkg::PIN_SEL1_RESET;
      misc_cfg <= '0;
      reg_rdata <= 8'h00;
      cfg_rdata <= 32'h0000_0000;
    end else begin
      pin_sel0 <= next_pin_sel0;
      pin_sel1 <= next_pin_sel1;
      misc_cfg <= next_misc_cfg;
      reg_rdata <= next_reg_rdata;
      cfg_rdata <= next_cfg_rdata;
    end
  end
  // ==========================================================================
  // Function decode
  // ==========================================================================
  pin_mux_pkg::pin_func_e func_203;
  pin_mux_pkg::pin_func_e func_206;
  pin_mux_pkg::pin_func_e func_128;
  pin_mux_pkg::pin_func_e func_133;
  pin_mux_pkg::pin_func_e func_204;
  assign func_203 = decode_sel(pin_sel0[pin_mux_pkg::SEL_PIN203_LSB +: 2], 1'b1, 1'b0);
  assign func_206 = decode_sel(pin_sel0[pin_mux_pkg::SEL_PIN206_LSB +: 2], 1'b1, 1'b0);
  assign func_128 = decode_sel(pin_sel0[pin_mux_pkg::SEL_PIN128_LSB +: 2], 1'b1, 1'b0);
  assign func_133 = decode_sel(pin_sel0[pin_mux_pkg::SEL_PIN133_LSB +: 2], 1'b1, 1'b1);
  assign func_204 = decode_sel(pin_sel1[pin_mux_pkg::SEL_PIN204_LSB +: 2], 1'b0, 1'b1);
  // ==========================================================================
  // Pin multiplexer
  // ==========================================================================
  pin_mux_pkg::pin_drive_s next_pin_203;
  pin_mux_pkg::pin_drive_s next_pin_206;
  pin_mux_pkg::pin_drive_s next_pin_128;
  pin_mux_pkg::pin_drive_s next_pin_133;
  pin_mux_pkg::pin_drive_s next_pin_204;
  pin_mux_pkg::pin_drive_s next_pin_131;
  logic next_power_good_seen;
  logic power_good_seen;
  logic led_a_src;
  logic led_b_src;
  always_comb begin
    // single socket uses the combined LED
    led_a_src = legacy.dual_socket ? legacy.socket_a_activity_led : legacy.combined_activity_led;
    led_b_src = legacy.dual_socket ? legacy.socket_b_activity_led : legacy.combined_activity_led;
    unique case (func_203)
      pin_mux_pkg::FUNC_GPIO: next_pin_203 = gpio_drive(gpio_out[0], gpio_oe[0]);
      default: begin
        next_pin_203 = open_drain(legacy.pin203_led_mode ? led_a_src : legacy.inta_assert);
      end
    endcase
    if (func_206 == pin_mux_pkg::FUNC_GPIO) begin
      next_pin_206 = gpio_drive(gpio_out[1], gpio_oe[1]);
    end else begin
      unique case (legacy.pin206_mode)
        pin_mux_pkg::MODE206_ISA_DATA: next_pin_206 = gpio_drive(legacy.isa_serial_irq_data, 1'b1);
        pin_mux_pkg::MODE206_LED: next_pin_206 = open_drain(led_b_src);
        default: next_pin_206 = gpio_drive(1'b0, 1'b0);
      endcase
    end
    // pin 128 speaker or GPIO three
    if (func_128 == pin_mux_pkg::FUNC_GPIO) begin
      next_pin_128 = gpio_drive(gpio_out[2], gpio_oe[2]);
    end else begin
      next_pin_128 = gpio_drive(legacy.speaker_output, legacy.speaker_enable);
    end
    unique case (func_133)
      pin_mux_pkg::FUNC_GPIO: next_pin_133 = gpio_drive(gpio_out[3], gpio_oe[3]);
      pin_mux_pkg::FUNC_PME: next_pin_133 = open_drain(pme_assert);
      default: begin
        if (legacy.hw_suspend_enable) begin
          next_pin_133 = gpio_drive(1'b0, 1'b0);
        end else begin
          next_pin_133 = open_drain(legacy.combined_activity_led);
        end
      end
    endcase
    // pin 204 power event, legacy interrupt or ring indicate
    if (func_204 == pin_mux_pkg::FUNC_PME) begin
      next_pin_204 = open_drain(pme_assert);
    end else if (legacy.ring_indicate_select) begin
      next_pin_204 = open_drain(legacy.ring_indicate_assert);
    end else begin
      next_pin_204 = open_drain(legacy.intb_assert);
    end
    // input until power good, sticky once seen
    next_power_good_seen = power_good_seen | sync_level[pin_mux_pkg::PWR_GOOD];
    // board clamps pin to the reset level until then, so never drive it
    next_pin_131.out = power_switch_serial_data_out;
    next_pin_131.oe = power_good_seen && power_switch_serial_data_oe;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_203 <= '0;
      pin_206 <= '0;
      pin_128 <= '0;
      pin_133 <= '0;
      pin_204 <= '0;
      pin_131 <= '0;
      power_good_seen <= 1'b0;
    end else begin
      pin_203 <= next_pin_203;
      pin_206 <= next_pin_206;
      pin_128 <= next_pin_128;
      pin_133 <= next_pin_133;
      pin_204 <= next_pin_204;
      pin_131 <= next_pin_131;
      power_good_seen <= next_power_good_seen;
    end
  end
  // ==========================================================================
  // Input functions
  // ==========================================================================
  // GPIO and serial data inputs are passed regardless of selection; serial irq and suspend inputs are gated by mode here
  logic [3:0] next_gpio_in;
  logic next_serial_irq_input_n;
  logic next_hardware_suspend_input_n;
  logic next_serial_data_in;
  always_comb begin
    next_gpio_in = {sync_level[pin_mux_pkg::PIN133], sync_level[pin_mux_pkg::PIN128],
                    sync_level[pin_mux_pkg::PIN206], sync_level[pin_mux_pkg::PIN203]};
    // serial irq input only in legacy input mode, idle high otherwise
    next_serial_irq_input_n = 1'b1;
    if (func_206 == pin_mux_pkg::FUNC_LEGACY &&
        legacy.pin206_mode == pin_mux_pkg::MODE206_SERIAL_IN) begin
      next_serial_irq_input_n = sync_level[pin_mux_pkg::PIN206];
    end
    // suspend input only in legacy mode with suspend enabled
    next_hardware_suspend_input_n = 1'b1;
    if (func_133 == pin_mux_pkg::FUNC_LEGACY && legacy.hw_suspend_enable) begin
      next_hardware_suspend_input_n = sync_level[pin_mux_pkg::PIN133];
    end
    next_serial_data_in = sync_level[pin_mux_pkg::PIN131];
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gpio_in <= 4'h0;
      serial_irq_input_n <= 1'b1;
      hardware_suspend_input_n <= 1'b1;
      power_switch_serial_data_in <= 1'b0;
    end else begin
      gpio_in <= next_gpio_in;
      serial_irq_input_n <= next_serial_irq_input_n;
      hardware_suspend_input_n <= next_hardware_suspend_input_n;
      power_switch_serial_data_in <= next_serial_data_in;
    end
  end
endmodule

// ---- pin_mux_pkg.sv ----
// Constants, encodings and carrier types for the multi-purpose pin function mux
package pin_mux_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int ADDR_W = 12;
  localparam int CFG_ADDR_W = 8;
  localparam logic [ADDR_W-1:0] PIN_SEL0_OFFSET = 12'h914;
  localparam logic [ADDR_W-1:0] PIN_SEL1_OFFSET = 12'h915;
  localparam logic [CFG_ADDR_W-1:0] CFG_MISC_OFFSET = 8'h98;

  localparam logic [7:0] PIN_SEL0_RESET = 8'h00;
  localparam logic [7:0] PIN_SEL1_RESET = 8'h00;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int SEL_PIN203_LSB = 0;
  localparam int SEL_PIN206_LSB = 2;
  localparam int SEL_PIN128_LSB = 4;
  localparam int SEL_PIN133_LSB = 6;
  localparam int SEL_PIN204_LSB = 0;

  localparam int CFG_SERIAL_INTR_BIT = 2;
  localparam int CFG_LOCK_BIT = 8;
  localparam int CFG_PREFETCH_OFF_BIT = 9;
  localparam int CFG_AUTO_RESET_OFF_BIT = 10;

  // ==========================================================================
  // Select field encodings
  // ==========================================================================
  localparam logic [1:0] SEL_LEGACY = 2'h0;
  localparam logic [1:0] SEL_GPIO = 2'h1;
  localparam logic [1:0] SEL_PME = 2'h2;

  // Pin index within the synchronised pin vector
  localparam int PIN203 = 0;
  localparam int PIN206 = 1;
  localparam int PIN128 = 2;
  localparam int PIN133 = 3;
  localparam int PIN204 = 4;
  localparam int PIN131 = 5;
  localparam int PWR_GOOD = 6;
  localparam int SYNC_W = 7;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    FUNC_LEGACY,
    FUNC_GPIO,
    FUNC_PME
  } pin_func_e;

  typedef enum logic [1:0] {
    MODE206_SERIAL_IN,
    MODE206_ISA_DATA,
    MODE206_LED
  } pin206_mode_e;

  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_s;

  // Controls and levels coming from the legacy pin logic
  typedef struct packed {
    logic inta_assert;
    logic intb_assert;
    logic ring_indicate_assert;
    logic ring_indicate_select;
    logic pin203_led_mode;
    pin206_mode_e pin206_mode;
    logic isa_serial_irq_data;
    logic socket_a_activity_led;
    logic socket_b_activity_led;
    logic combined_activity_led;
    logic dual_socket;
    logic speaker_output;
    logic speaker_enable;
    logic hw_suspend_enable;
  } legacy_s;

  typedef struct packed {
    logic auto_reset_off;
    logic prefetch_off;
    logic lock;
    logic serial_intr_en;
  } misc_cfg_s;

endpackage

// ---- level_sync.sv ----
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ns

module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ==========================================================================
  // Stages
  // ==========================================================================
  // First stage feeds only the second stage
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// ---- pin_board_model.sv ----
// Board-side model of the multiplexed pins and the serial-data power-on clamp
`timescale 1ns/1ns
module pin_board_model (
  input wire logic arst_n,
  input wire logic system_power_good,
  input wire pin_mux_pkg::pin_drive_s pin_203,
  input wire pin_mux_pkg::pin_drive_s pin_206,
  input wire pin_mux_pkg::pin_drive_s pin_128,
  input wire pin_mux_pkg::pin_drive_s pin_133,
  input wire pin_mux_pkg::pin_drive_s pin_204,
  input wire pin_mux_pkg::pin_drive_s pin_131,
  input wire logic [5:0] ext_en,
  input wire logic [5:0] ext_level,
  output logic [5:0] pin_in
);
  pin_mux_pkg::pin_drive_s drv [6];
  // ==========================================================================
  // Wire levels
  always_comb begin
    drv = '{pin_203, pin_206, pin_128, pin_133, pin_204, pin_131};
    for (int i = 0; i < 6; i++) begin
      pin_in[i] = drv[i].oe ? drv[i].out : (ext_en[i] ? ext_level[i] : 1'b1);
    end
    if (!system_power_good) begin
      pin_in[5] = arst_n;
    end
  end
endmodule

// ---- pin_mux_chk.sv ----
// Port-level assertions for the pin function mux
`timescale 1ns/1ns
module pin_mux_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [pin_mux_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic cfg_wr,
  input wire logic [pin_mux_pkg::CFG_ADDR_W-1:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire pin_mux_pkg::misc_cfg_s misc_cfg,
  input wire logic segment_reset,
  input wire logic pme_enable,
  input wire logic in_d3,
  input wire logic pme_assert,
  input wire pin_mux_pkg::legacy_s legacy,
  input wire logic [3:0] gpio_out,
  input wire logic [3:0] gpio_oe,
  input wire logic power_switch_serial_data_oe,
  input wire logic system_power_good,
  input wire pin_mux_pkg::pin_drive_s pin_203,
  input wire pin_mux_pkg::pin_drive_s pin_133,
  input wire pin_mux_pkg::pin_drive_s pin_204,
  input wire pin_mux_pkg::pin_drive_s pin_131
);
  logic [7:0] sel0, sel1, next_sel0, next_sel1;
  logic pg_seen, next_pg_seen;
  logic [2:0] pg_cnt, next_pg_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ==========================================================================
  // Shadow of the select registers, so outputs can be tied to stored fields
  always_comb begin
    next_sel0 = sel0;
    next_sel1 = sel1;
    next_pg_seen = pg_seen | system_power_good;
    next_pg_cnt = (pg_seen && pg_cnt != 3'h7) ? pg_cnt + 3'h1 : pg_cnt;
    if (segment_reset) begin
      if (!(pme_enable && in_d3)) begin
        next_sel0 = 8'h00;
        next_sel1 = 8'h00;
      end
    end else if (reg_wr && !misc_cfg.lock) begin
      if (reg_addr == pin_mux_pkg::PIN_SEL0_OFFSET) next_sel0 = reg_wdata;
      if (reg_addr == pin_mux_pkg::PIN_SEL1_OFFSET) next_sel1 = reg_wdata;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sel0 <= 8'h00;
      sel1 <= 8'h00;
      pg_seen <= 1'b0;
      pg_cnt <= 3'h0;
    end else begin
      sel0 <= next_sel0;
      sel1 <= next_sel1;
      pg_seen <= next_pg_seen;
      pg_cnt <= next_pg_cnt;
    end
  end
  // ==========================================================================
  // Properties
  property p_pin131_held; !pg_seen |-> !pin_131.oe; endproperty
  a_pin131_held: assert property (p_pin131_held)
    else $error("serial data pin driven before power good");
  property p_pin131_drive;
    pg_cnt == 3'h7 |-> pin_131.oe == $past(power_switch_serial_data_oe);
  endproperty
  a_pin131_drive: assert property (p_pin131_drive)
    else $error("serial data pin not driven by engine after power good");
  property p_rdata_reset; $rose(arst_n) |-> reg_rdata == 8'h00 && cfg_rdata == 32'h0; endproperty
  a_rdata_reset: assert property (p_rdata_reset)
    else $error("read data not zero after reset");
  property p_lock_set;
    cfg_wr && cfg_addr == pin_mux_pkg::CFG_MISC_OFFSET && cfg_be[1] && !segment_reset
      |=> misc_cfg.lock == $past(cfg_wdata[pin_mux_pkg::CFG_LOCK_BIT]);
  endproperty
  a_lock_set: assert property (p_lock_set)
    else $error("lock bit not written");
  property p_intr_en;
    cfg_wr && cfg_addr == pin_mux_pkg::CFG_MISC_OFFSET && cfg_be[0] && !segment_reset
      |-> ##1 misc_cfg.serial_intr_en == $past(cfg_wdata[pin_mux_pkg::CFG_SERIAL_INTR_BIT]);
  endproperty
  a_intr_en: assert property (p_intr_en)
    else $error("serial interrupt enable not written");
  property p_pme_133;
    sel0[7:6] == pin_mux_pkg::SEL_PME |=> pin_133.oe == $past(pme_assert) && !pin_133.out;
  endproperty
  a_pme_133: assert property (p_pme_133)
    else $error("power event missing on pin 133");
  property p_pme_204;
    sel1[1:0] == pin_mux_pkg::SEL_PME |=> pin_204.oe == $past(pme_assert) && !pin_204.out;
  endproperty
  a_pme_204: assert property (p_pme_204)
    else $error("power event missing on pin 204");
  property p_gpio_203;
    sel0[1:0] == pin_mux_pkg::SEL_GPIO |=> pin_203 == $past({gpio_out[0], gpio_oe[0]});
  endproperty
  a_gpio_203: assert property (p_gpio_203)
    else $error("pin 203 does not follow gpio one");
  property p_bad_133; sel0[7:6] == 2'h3 && legacy.hw_suspend_enable |=> !pin_133.oe; endproperty
  a_bad_133: assert property (p_bad_133)
    else $error("pin 133 not legacy for undefined code");
  property p_readback;
    reg_rd && reg_addr == pin_mux_pkg::PIN_SEL0_OFFSET |=> reg_rdata == $past(sel0);
  endproperty
  a_readback: assert property (p_readback)
    else $error("select register read back wrong");
endmodule

bind legacy_pin_function_mux pin_mux_chk pin_mux_chk_i (.clk, .arst_n, .reg_wr, .reg_rd,
  .reg_addr, .reg_wdata, .reg_rdata, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata,
  .misc_cfg, .segment_reset, .pme_enable, .in_d3, .pme_assert, .legacy, .gpio_out,
  .gpio_oe, .power_switch_serial_data_oe, .system_power_good, .pin_203, .pin_133,
  .pin_204, .pin_131);

// ---- legacy_pin_function_mux_tb_top.sv ----
// Self-checking testbench for the pin function mux
`timescale 1ns/1ns
module legacy_pin_function_mux_tb_top;
  logic clk, arst_n, reg_wr, reg_rd, cfg_wr, cfg_rd, segment_reset, pme_enable, in_d3;
  logic pme_assert, serial_irq_input_n, hardware_suspend_input_n, system_power_good;
  logic power_switch_serial_data_out, power_switch_serial_data_oe, power_switch_serial_data_in;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, cfg_addr, d;
  logic [3:0] cfg_be, gpio_out, gpio_oe, gpio_in;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [5:0] pin_in, ext_en, ext_level;
  pin_mux_pkg::misc_cfg_s misc_cfg;
  pin_mux_pkg::legacy_s legacy;
  pin_mux_pkg::pin_drive_s pin_203, pin_206, pin_128, pin_133, pin_204, pin_131;
  logic [31:0] exp_q [$];
  logic rd_pend, rd_cfg;
  int errors, compares, seed;
  legacy_pin_function_mux legacy_pin_function_mux_i (.clk, .arst_n, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata,
    .cfg_rdata, .misc_cfg, .segment_reset, .pme_enable, .in_d3, .pme_assert, .legacy,
    .gpio_out, .gpio_oe, .gpio_in, .serial_irq_input_n, .hardware_suspend_input_n,
    .power_switch_serial_data_out, .power_switch_serial_data_oe, .power_switch_serial_data_in,
    .system_power_good, .pin_in, .pin_203, .pin_206, .pin_128, .pin_133, .pin_204, .pin_131);
  pin_board_model pin_board_model_i (.arst_n, .system_power_good, .pin_203, .pin_206,
    .pin_128, .pin_133, .pin_204, .pin_131, .ext_en, .ext_level, .pin_in);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ==========================================================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic reg_w(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_r(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back({24'h0, e});
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task automatic cfg_w(input logic [3:0] be, input logic [31:0] v);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_addr <= pin_mux_pkg::CFG_MISC_OFFSET;
    cfg_be <= be;
    cfg_wdata <= v;
    @(posedge clk);
    cfg_wr <= 1'b0;
  endtask
  task automatic cfg_r(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    cfg_rd <= 1'b0;
  endtask
  task automatic pins(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic seg_rst(input logic keep);
    @(posedge clk);
    segment_reset <= 1'b1;
    pme_enable <= keep;
    in_d3 <= 1'b1;
    @(posedge clk);
    segment_reset <= 1'b0;
  endtask
  // ==========================================================================
  // Read-data monitor: read data is valid the cycle after the strobe
  always @(posedge clk) begin
    rd_pend <= reg_rd | cfg_rd;
    rd_cfg <= cfg_rd;
  end
  always @(negedge clk) begin
    if (rd_pend === 1'b1) check(rd_cfg ? cfg_rdata : {24'h0, reg_rdata}, exp_q.pop_front());
  end
  initial begin
    #200000;
    errors++;
    end_sim();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    seed = 32'hb5a5;
    {arst_n, reg_wr, reg_rd, cfg_wr, cfg_rd, segment_reset, pme_enable, in_d3} = '0;
    {pme_assert, system_power_good, power_switch_serial_data_out} = '0;
    power_switch_serial_data_oe = 1'b1;
    {reg_addr, reg_wdata, cfg_addr, cfg_be, cfg_wdata, gpio_out, gpio_oe} = '0;
    {ext_en, ext_level} = '0;
    legacy = '0;
    legacy.hw_suspend_enable = 1'b1;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    pins(4);
    check(pin_131.oe, 1'b0);
    reg_r(pin_mux_pkg::PIN_SEL0_OFFSET, 8'h00);
    reg_r(pin_mux_pkg::PIN_SEL1_OFFSET, 8'h00);
    reg_r(12'h916, 8'h00);
    cfg_r(pin_mux_pkg::CFG_MISC_OFFSET, 32'h0);
    cfg_r(8'h9C, 32'h0);
    repeat (4) begin
      d = 8'($random(seed));
      reg_w(pin_mux_pkg::PIN_SEL0_OFFSET, d);
      reg_r(pin_mux_pkg::PIN_SEL0_OFFSET, d);
    end
    reg_w(pin_mux_pkg::PIN_SEL1_OFFSET, 8'hFC);
    reg_r(pin_mux_pkg::PIN_SEL1_OFFSET, 8'hFC);
    reg_w(pin_mux_pkg::PIN_SEL0_OFFSET, 8'h55);
    repeat (3) begin
      @(posedge clk);
      gpio_out <= 4'($random(seed));
      gpio_oe <= 4'($random(seed));
      pins(1);
      check({pin_133.oe, pin_128.oe, pin_206.oe, pin_203.oe}, gpio_oe);
      check({pin_133.out, pin_128.out, pin_206.out, pin_203.out} & gpio_oe, gpio_out & gpio_oe);
      pins(3);
      check(gpio_in, 4'((gpio_out & gpio_oe) | ~gpio_oe));
    end
    @(posedge clk);
    gpio_oe <= 4'hF;
    pme_assert <= 1'b1;
    reg_w(pin_mux_pkg::PIN_SEL0_OFFSET, 8'hAA);
    reg_w(pin_mux_pkg::PIN_SEL1_OFFSET, 8'h02);
    pins(1);
    check({pin_133.oe, pin_133.out, pin_204.oe, pin_204.out}, 4'hA);
    check({pin_206.oe, pin_203.oe}, 2'h0);
    @(posedge clk);
    pme_assert <= 1'b0;
    pins(1);
    check({pin_133.oe, pin_204.oe}, 2'h0);
    @(posedge clk);
    pme_assert <= 1'b1;
    ext_en <= 6'h0A;
    reg_w(pin_mux_pkg::PIN_SEL0_OFFSET, 8'hFF);
    reg_w(pin_mux_pkg::PIN_SEL1_OFFSET, 8'h03);
    pins(4);
    check({pin_133.oe, pin_206.oe, pin_204.oe, pin_203.oe}, 4'h0);
    check({hardware_suspend_input_n, serial_irq_input_n}, 2'h0);
    @(posedge clk);
    legacy.pin203_led_mode <= 1'b1;
    legacy.pin206_mode <= pin_mux_pkg::MODE206_LED;
    legacy.combined_activity_led <= 1'b1;
    pins(1);
    check({pin_203.oe, pin_203.out, pin_206.oe, serial_irq_input_n}, 4'hB);
    cfg_w(4'h2, 32'h704);
    cfg_r(pin_mux_pkg::CFG_MISC_OFFSET, 32'h700);
    cfg_w(4'h1, 32'h704);
    pins(0);
    check(misc_cfg, 4'hF);
    reg_w(pin_mux_pkg::PIN_SEL0_OFFSET, 8'h11);
    reg_w(pin_mux_pkg::PIN_SEL1_OFFSET, 8'h00);
    reg_r(pin_mux_pkg::PIN_SEL0_OFFSET, 8'hFF);
    reg_r(pin_mux_pkg::PIN_SEL1_OFFSET, 8'h03);
    seg_rst(1'b1);
    reg_r(pin_mux_pkg::PIN_SEL0_OFFSET, 8'hFF);
    cfg_r(pin_mux_pkg::CFG_MISC_OFFSET, 32'h0);
    seg_rst(1'b0);
    reg_r(pin_mux_pkg::PIN_SEL0_OFFSET, 8'h00);
    reg_r(pin_mux_pkg::PIN_SEL1_OFFSET, 8'h00);
    @(posedge clk);
    system_power_good <= 1'b1;
    pins(6);
    check({pin_131.oe, pin_131.out}, 2'h2);
    @(posedge clk);
    power_switch_serial_data_out <= 1'b1;
    pins(4);
    check({pin_131.out, power_switch_serial_data_in}, 2'h3);
    @(posedge clk);
    arst_n <= 1'b0;
    pins(1);
    check(pin_131.oe, 1'b0);
    @(posedge clk);
    arst_n <= 1'b1;
    reg_r(pin_mux_pkg::PIN_SEL0_OFFSET, 8'h00);
    pins(8);
    end_sim();
  end
endmodule
